// ===== verilog/mbc_map.svh
// Register offsets, field positions, reset values and timing counts of the bus controller
`ifndef MBC_MAP_SVH
`define MBC_MAP_SVH
`define MBC_OFF_CTRL 8'h00
`define MBC_OFF_STAT 8'h04
`define MBC_OFF_WAIT 8'h08
`define MBC_OFF_LADDR 8'h0C
`define MBC_OFF_MADDR 8'h10
`define MBC_OFF_MDATA 8'h14
`define MBC_CTRL_RUN 0
`define MBC_CTRL_FASTMODE 1
`define MBC_CTRL_SYNC 2
`define MBC_CTRL_FIQ 3
`define MBC_CTRL_IRQ 4
`define MBC_CTRL_ALE 5
`define MBC_CTRL_HOLD 6
`define MBC_CTRL_RESET 7'h20
`define MBC_WAIT_RESET 4'h0
`define MBC_STAT_LOCK 0
`define MBC_STAT_GRANT 1
`define MBC_STAT_RUN 2
`define MBC_STAT_BUSY 3
`define MBC_STAT_TOUT 4
`define MBC_CLK_PERIOD_NS 5
`define MBC_MCLK_PERIOD_NS 80
`define MBC_MCLK_HALF (`MBC_MCLK_PERIOD_NS / `MBC_CLK_PERIOD_NS / 2)
`define MBC_FAST_CORE_CLOCK_HALF 2
`define MBC_RST_MCLK_CYCLES 5
`define MBC_RST_FAST_CORE_CLOCK_CYCLES 2
`endif

// ===== verilog/mbc_pkg.sv
// Types shared by the bus controller
package mbc_pkg;
   typedef enum logic [1:0] {MBC_IDLE, MBC_ADDR, MBC_HOLD} mbc_state_t;
endpackage : mbc_pkg

// ===== verilog/mbc_host.sv
// Memory system and bus manager that serves the processor at its pins
// Notes on behaviour
// R1 - Address enable low floats address group
// R2 - Abort flagged only during external accesses
// R3 - Address group follows latch enable input
// R4 - Byte lane selects show accessed bytes
// R5 - Read data valid before falling clock
// R6 - Data bus enable high unless bus granted
// R7 - Legacy mode runs core on fast clock
// R8 - Mode select: low legacy, high fast
// R9 - No grant while locked sequence runs
// R10 - Memory clock free-running, wait stretches
// R11 - Request enable low floats request, sequential
// R12 - Byte/word high word, low byte
// R13 - Fast interrupt held low until served
// R14 - Normal interrupt, lower priority, same shape
// R15 - Request pipelined, announces next cycle access
// R16 - Reset low aborts, restart from zero
// R17 - Reset low five memory, two fast clocks
// R18 - Wait held high during reset
// R19 - Read/write high write, low read
// R20 - Wait changes only in clock low phase
// R21 - Sync select ignored in fast mode
// R22 - Test reset low, test inputs tied low; here test reset follows the system reset
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "mbc_map.svh"
module mbc_host #(
   parameter int DEPTH_LOG2 = 6,
   parameter int MCLK_HALF = `MBC_MCLK_HALF,
   parameter int FAST_CORE_CLOCK_HALF = `MBC_FAST_CORE_CLOCK_HALF
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Software register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [31:0] reg_rdata_o,
   // Processor outputs
   input wire logic [31:0] addr_i,
   input wire logic [3:0] byte_lane_select_n_i,
   input wire logic byte_word_n_i,
   input wire logic read_write_n_i,
   input wire logic lock_i,
   input wire logic memory_request_n_i,
   input wire logic sequential_address_i,
   input wire logic [2:0] factory_test_out_i,
   // Data bus
   input wire logic [31:0] data_i,
   output logic [31:0] data_o,
   output logic data_oe_o,
   // Clocks and controls to the processor
   output logic mclk_o,
   output logic fast_core_clock_o,
   output logic wait_n_o,
   output logic abort_o,
   output logic address_latch_enable_o,
   output logic addr_bus_output_enable_o,
   output logic data_bus_output_enable_o,
   output logic req_seq_output_enable_o,
   output logic bus_mode_select_o,
   output logic sync_async_select_o,
   output logic fast_interrupt_n_o,
   output logic normal_interrupt_n_o,
   output logic system_reset_n_o,
   output logic test_reset_n_o,
   output logic [15:1] factory_test_in_o
);
   import mbc_pkg::*;

   initial
   begin
      if (DEPTH_LOG2 < 1 || DEPTH_LOG2 > 16 || MCLK_HALF < 4 || FAST_CORE_CLOCK_HALF < 1)
      begin
         $error("mbc_host: unsupported parameter values");
      end
   end

   // ****************************************
   // Clock generation
   // ****************************************
   logic [7:0] mdiv;
   logic [7:0] fdiv;
   wire mwrap = (mdiv == 8'(MCLK_HALF - 1));
   wire rise_ev = mwrap & ~mclk_o;
   wire fall_ev = mwrap & mclk_o;
   wire fwrap = (fdiv == 8'(FAST_CORE_CLOCK_HALF - 1));
   // Memory clock runs free; slow slaves use wait instead [R10]
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mdiv <= 8'h00;
         fdiv <= 8'h00;
         mclk_o <= 1'b0;
         fast_core_clock_o <= 1'b0;
      end
      else
      begin
         mdiv <= mwrap ? 8'h00 : mdiv + 8'h01;
         fdiv <= fwrap ? 8'h00 : fdiv + 8'h01;
         mclk_o <= mclk_o ^ mwrap;
         fast_core_clock_o <= fast_core_clock_o ^ fwrap; // [R7]
      end
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [75:0] pin_s1;
   logic [75:0] pin_s2;
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pin_s1 <= 76'h0;
         pin_s2 <= 76'h0;
      end
      else
      begin
         pin_s1 <= {addr_i, byte_lane_select_n_i, byte_word_n_i, read_write_n_i, lock_i,
                    memory_request_n_i, sequential_address_i, data_i, factory_test_out_i};
         pin_s2 <= pin_s1;
      end
   end
   wire [31:0] a_s = pin_s2[75:44];
   wire [3:0] bls_s = pin_s2[43:40];
   wire rw_s = pin_s2[38];
   wire lock_s = pin_s2[37];
   wire mreq_n_s = pin_s2[36];
   wire [31:0] d_s = pin_s2[34:3];
   wire [2:0] tout_s = pin_s2[2:0];

   // ****************************************
   // Software registers
   // ****************************************
   logic [6:0] ctrl;
   logic [3:0] wait_cfg;
   logic [DEPTH_LOG2-1:0] sw_addr;
   wire wr_ctrl = reg_write_i && reg_addr_i == `MBC_OFF_CTRL;
   wire wr_wait = reg_write_i && reg_addr_i == `MBC_OFF_WAIT;
   wire wr_maddr = reg_write_i && reg_addr_i == `MBC_OFF_MADDR;
   wire wr_mdata = reg_write_i && reg_addr_i == `MBC_OFF_MDATA;
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ctrl <= `MBC_CTRL_RESET;
         wait_cfg <= `MBC_WAIT_RESET;
         sw_addr <= '0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= reg_wdata_i[6:0];
         if (wr_wait)
            wait_cfg <= reg_wdata_i[3:0];
         if (wr_maddr)
            sw_addr <= reg_wdata_i[DEPTH_LOG2-1:0];
      end
   end
   assign bus_mode_select_o = ctrl[`MBC_CTRL_FASTMODE]; // [R8]
   // Sync select has no meaning in fast mode, so it is parked low there [R21]
   assign sync_async_select_o = ctrl[`MBC_CTRL_SYNC] & ~ctrl[`MBC_CTRL_FASTMODE];
   // Levels stay low until software clears them, once served [R13] [R14]
   assign fast_interrupt_n_o = ~ctrl[`MBC_CTRL_FIQ];
   assign normal_interrupt_n_o = ~ctrl[`MBC_CTRL_IRQ];
   assign address_latch_enable_o = ctrl[`MBC_CTRL_ALE]; // [R3]
   assign factory_test_in_o = 15'h0000; // [R22]

   // ****************************************
   // Reset sequencing
   // ****************************************
   logic [2:0] rst_mcnt;
   logic [1:0] rst_fcnt;
   wire f_rise = fwrap & ~fast_core_clock_o;
   wire rst_long = rst_mcnt >= 3'(`MBC_RST_MCLK_CYCLES) && rst_fcnt >= 2'(`MBC_RST_FAST_CORE_CLOCK_CYCLES);
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_mcnt <= 3'h0;
         rst_fcnt <= 2'h0;
         system_reset_n_o <= 1'b0;
      end
      else if (!ctrl[`MBC_CTRL_RUN])
      begin
         rst_mcnt <= 3'h0;
         rst_fcnt <= 2'h0;
         system_reset_n_o <= 1'b0;
      end
      else if (!system_reset_n_o)
      begin
         if (rise_ev && !rst_long)
            rst_mcnt <= rst_mcnt + 3'h1;
         if (f_rise && rst_fcnt != 2'h3)
            rst_fcnt <= rst_fcnt + 2'h1;
         // Release only on a clock rise after the full hold [R17] [R16]
         if (rise_ev && rst_long)
            system_reset_n_o <= 1'b1;
      end
   end
   // Test port reset follows the system reset so both are pulsed [R22]
   assign test_reset_n_o = system_reset_n_o;

   // ****************************************
   // Bus grant
   // ****************************************
   mbc_state_t state;
   mbc_state_t next_state;
   logic grant;
   wire next_grant = ctrl[`MBC_CTRL_HOLD] & (grant | (~lock_s & state == MBC_IDLE)); // [R9]
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         grant <= 1'b0;
      else
         grant <= next_grant;
   end
   // Enables stay high except while another master owns the bus [R6] [R1] [R11]
   assign addr_bus_output_enable_o = ~grant;
   assign data_bus_output_enable_o = ~grant;
   assign req_seq_output_enable_o = ~grant;

   // ****************************************
   // Access engine
   // ****************************************
   logic [31:0] mem [0:(1<<DEPTH_LOG2)-1];
   logic [31:0] acc_addr;
   logic acc_write;
   logic [3:0] acc_bls;
   logic [3:0] wcnt;
   wire out_range = a_s[31:DEPTH_LOG2+2] != '0;
   wire [DEPTH_LOG2-1:0] a_idx = a_s[DEPTH_LOG2+1:2];
   wire [DEPTH_LOG2-1:0] acc_idx = acc_addr[DEPTH_LOG2+1:2];
   // Reads take at least one wait so data settle before the sampling fall [R5]
   wire [3:0] waits = (rw_s || wait_cfg != 4'h0) ? wait_cfg : 4'h1;
   wire done = rise_ev && state == MBC_HOLD && wait_n_o;
   // Request low in the previous low phase announces this cycle [R15]
   wire start = rise_ev && (state == MBC_IDLE || done) && !mreq_n_s && !grant;

   always_comb
   begin
      next_state = state;
      if (start)
         next_state = MBC_ADDR;
      else if (done || (rise_ev && state == MBC_IDLE))
         next_state = MBC_IDLE;
      else if (fall_ev && state == MBC_ADDR)
         next_state = MBC_HOLD;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         state <= MBC_IDLE;
      else if (!system_reset_n_o)
         state <= MBC_IDLE; // [R16]
      else
         state <= next_state;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         acc_addr <= 32'h0000_0000;
         acc_write <= 1'b0;
         acc_bls <= 4'hF;
         wcnt <= 4'h0;
         wait_n_o <= 1'b1;
         abort_o <= 1'b0;
         data_o <= 32'h0000_0000;
         data_oe_o <= 1'b0;
      end
      else if (!system_reset_n_o)
      begin
         wait_n_o <= 1'b1; // [R18]
         abort_o <= 1'b0;
         data_oe_o <= 1'b0;
      end
      else if (fall_ev && state == MBC_ADDR)
      begin
         // Address group was settled during the high phase [R12] [R19] [R4]
         acc_addr <= a_s;
         acc_write <= rw_s;
         acc_bls <= bls_s;
         abort_o <= out_range; // [R2]
         data_o <= mem[a_idx];
         data_oe_o <= ~rw_s & data_bus_output_enable_o; // [R5] [R6]
         wcnt <= 4'h1;
         wait_n_o <= (waits == 4'h0); // [R20]
      end
      else if (fall_ev && state == MBC_HOLD && !wait_n_o)
      begin
         wcnt <= wcnt + 4'h1;
         wait_n_o <= (wcnt >= waits); // [R20]
      end
      else if (done)
      begin
         abort_o <= 1'b0;
         data_oe_o <= 1'b0;
      end
   end

   // Link writes win over software writes in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (done && acc_write && !abort_o)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (!acc_bls[i])
               mem[acc_idx][8*i +: 8] <= d_s[8*i +: 8];
         end
      end
      else if (wr_mdata)
         mem[sw_addr] <= reg_wdata_i;
   end

   // ****************************************
   // Read port
   // ****************************************
   wire [31:0] stat = {25'h0, tout_s, state != MBC_IDLE, system_reset_n_o, grant, lock_s};
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reg_rdata_o <= 32'h0000_0000;
      else if (reg_read_i)
      begin
         case (reg_addr_i)
            `MBC_OFF_CTRL: reg_rdata_o <= {25'h0, ctrl};
            `MBC_OFF_STAT: reg_rdata_o <= stat;
            `MBC_OFF_WAIT: reg_rdata_o <= {28'h0, wait_cfg};
            `MBC_OFF_LADDR: reg_rdata_o <= acc_addr;
            `MBC_OFF_MADDR: reg_rdata_o <= 32'(sw_addr);
            `MBC_OFF_MDATA: reg_rdata_o <= mem[sw_addr];
            default: reg_rdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wait_reset_a: assert property (!system_reset_n_o |-> wait_n_o) // [R18]
      else $error("wait low during reset");
   wait_phase_a: assert property ($changed(wait_n_o) |-> !mclk_o) // [R20]
      else $error("wait changed outside low phase");
   abort_window_a: assert property (abort_o |-> state == MBC_HOLD) // [R2]
      else $error("abort outside an access");
   read_drive_a: assert property (data_oe_o |-> !acc_write && state == MBC_HOLD) // [R5]
      else $error("data driven outside a read");
   grant_lock_a: assert property (!data_bus_output_enable_o && !$past(grant) |-> !$past(lock_s)) // [R9]
      else $error("bus granted during locked sequence");
   reset_hold_a: assert property ($rose(system_reset_n_o) |-> $past(rst_mcnt) == 3'h5) // [R17]
      else $error("reset released too early");
   sync_ignored_a: assert property (bus_mode_select_o |-> !sync_async_select_o) // [R21]
      else $error("sync select driven in fast mode");
   test_low_a: assert property (factory_test_in_o == 15'h0000 && test_reset_n_o == system_reset_n_o) // [R22]
      else $error("test port not parked");
   read_wait_a: assert property (fall_ev && state == MBC_ADDR && !rw_s |=> !wait_n_o) // [R5]
      else $error("read without wait state");
   read_cov: cover property (done && !acc_write);
   write_cov: cover property (done && acc_write);
   grant_cov: cover property ($rose(grant));
endmodule : mbc_host
`default_nettype wire

// ===== bench/mbc_cpu_model.sv
// Behavioural processor that drives the bus controller's pins
`timescale 1ns/100ps
`default_nettype none
module mbc_cpu_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Pins from the controller
   input wire logic mclk_i,
   input wire logic wait_n_i,
   input wire logic abort_i,
   input wire logic address_latch_enable_i,
   input wire logic addr_bus_output_enable_i,
   input wire logic data_bus_output_enable_i,
   input wire logic req_seq_output_enable_i,
   input wire logic system_reset_n_i,
   input wire logic [31:0] data_i,
   // Pins to the controller
   output logic [31:0] addr_o,
   output logic [3:0] byte_lane_select_n_o,
   output logic byte_word_n_o,
   output logic read_write_n_o,
   output logic memory_request_n_o,
   output logic sequential_address_o,
   output logic [31:0] data_o,
   output logic data_oe_o,
   // Bench command side
   input wire logic cmd_go_i,
   input wire logic cmd_write_i,
   input wire logic [31:0] cmd_addr_i,
   input wire logic [31:0] cmd_data_i,
   input wire logic [3:0] cmd_lanes_i,
   output logic done_o,
   output logic [31:0] rd_data_o,
   output logic abort_seen_o,
   output logic viol_o
);
   logic m_q, w_q, s_q, act, wr, wr_lat, mreq_int;
   logic [31:0] a_int, a_lat;
   logic [3:0] l_int, l_lat;
   int n_m;
   wire m_rise = mclk_i & ~m_q;
   wire m_fall = ~mclk_i & m_q;
   wire abe = addr_bus_output_enable_i;
   wire req_seq_output_enable = req_seq_output_enable_i;
   // ****************************************
   // Pins; a released pin other than the byte lane selects shows the inverse of its last value
   // ****************************************
   assign addr_o = abe ? a_lat : ~a_lat;
   assign read_write_n_o = abe ? wr_lat : ~wr_lat;
   assign byte_word_n_o = abe ? (l_lat == 4'h0) : (l_lat != 4'h0);
   assign byte_lane_select_n_o = l_lat;
   assign memory_request_n_o = req_seq_output_enable ? mreq_int : ~mreq_int;
   assign sequential_address_o = req_seq_output_enable ? ~mreq_int : mreq_int;
   assign data_oe_o = act & wr & ~mclk_i & data_bus_output_enable_i;
   assign data_o = cmd_data_i;
   // Transparent while enabled, so the address group moves only then
   always_ff @(posedge clk_i)
      if (address_latch_enable_i)
      begin
         a_lat <= a_int;
         l_lat <= l_int;
         wr_lat <= wr;
      end
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         m_q <= 1'b0;
         w_q <= 1'b1;
         s_q <= 1'b0;
         act <= 1'b0;
         wr <= 1'b0;
         a_int <= 32'h0000_0000;
         l_int <= 4'hf;
         mreq_int <= 1'b1;
         done_o <= 1'b0;
         rd_data_o <= 32'h0000_0000;
         abort_seen_o <= 1'b0;
         viol_o <= 1'b0;
         n_m <= 0;
      end
      else
      begin
         m_q <= mclk_i;
         w_q <= wait_n_i;
         s_q <= system_reset_n_i;
         done_o <= 1'b0;
         if (wait_n_i != w_q && !m_fall)
            viol_o <= 1'b1;
         if (!system_reset_n_i && !wait_n_i)
            viol_o <= 1'b1;
         if (!system_reset_n_i)
            n_m <= n_m + int'(m_rise);
         if (system_reset_n_i && !s_q && n_m < 5)
            viol_o <= 1'b1;
         if (system_reset_n_i && !s_q)
            n_m <= 0;
         if (m_fall)
            mreq_int <= ~(cmd_go_i & ~act & system_reset_n_i);
         if (m_rise && !system_reset_n_i)
         begin
            a_int <= a_int + 32'h0000_0004;
            act <= 1'b0;
         end
         else if (m_rise && act && wait_n_i)
         begin
            act <= 1'b0;
            done_o <= 1'b1;
         end
         else if (m_rise && !mreq_int)
         begin
            act <= 1'b1;
            a_int <= cmd_addr_i;
            wr <= cmd_write_i;
            l_int <= cmd_lanes_i;
            abort_seen_o <= 1'b0;
         end
         if (act && !wr && !mclk_i && wait_n_i)
            rd_data_o <= data_i;
         if (act && abort_i)
            abort_seen_o <= 1'b1;
      end
endmodule : mbc_cpu_model
`default_nettype wire

// ===== bench/test_mbc_host.sv
// Self-checking bench for the memory bus controller
`timescale 1ns/100ps
`default_nettype none
`include "mbc_map.svh"
module test_mbc_host;
   logic clk_i = 1'b0, rst_n_i = 1'b0, ws = 1'b0, rs = 1'b0, go = 1'b0, cwr = 1'b0;
   logic [7:0] ra = 8'h00;
   logic [31:0] wd = 32'h0000_0000, ca = 32'h0000_0000, cd = 32'h0000_0000;
   logic [31:0] last = 32'h0000_0000, rdat, a, hd, pd, pdat, v;
   logic [3:0] bls, cl = 4'h0;
   logic [15:1] tin;
   logic bw, rnw, mreq, seq, hoe, poe, mclk, wn, ab, ale, abe, dbe, req_seq_output_enable;
   logic bms, sas, fiq, irq, srn, trn, done, aseen, viol, fcc, f0, m0;
   logic lk = 1'b0;
   int err_total = 0, comparisons = 0, seed = 47, cycles = 0;
   logic [31:0] mem [64];
   // Undriven data bus flips every cycle so stale data never matches
   wire [31:0] dw = poe ? pd : (hoe ? hd : ~last);
   mbc_host uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(ra), .reg_wdata_i(wd),
      .reg_write_i(ws), .reg_read_i(rs), .reg_rdata_o(rdat), .addr_i(a),
      .byte_lane_select_n_i(bls), .byte_word_n_i(bw), .read_write_n_i(rnw), .lock_i(lk),
      .memory_request_n_i(mreq), .sequential_address_i(seq), .factory_test_out_i(3'h0),
      .data_i(dw), .data_o(hd), .data_oe_o(hoe), .mclk_o(mclk), .fast_core_clock_o(fcc),
      .wait_n_o(wn), .abort_o(ab), .address_latch_enable_o(ale), .addr_bus_output_enable_o(abe),
      .data_bus_output_enable_o(dbe), .req_seq_output_enable_o(req_seq_output_enable), .bus_mode_select_o(bms),
      .sync_async_select_o(sas), .fast_interrupt_n_o(fiq), .normal_interrupt_n_o(irq),
      .system_reset_n_o(srn), .test_reset_n_o(trn), .factory_test_in_o(tin));
   mbc_cpu_model cpu (.clk_i(clk_i), .rst_n_i(rst_n_i), .mclk_i(mclk), .wait_n_i(wn),
      .abort_i(ab), .address_latch_enable_i(ale), .addr_bus_output_enable_i(abe),
      .data_bus_output_enable_i(dbe), .req_seq_output_enable_i(req_seq_output_enable), .system_reset_n_i(srn),
      .data_i(dw), .addr_o(a), .byte_lane_select_n_o(bls), .byte_word_n_o(bw),
      .read_write_n_o(rnw), .memory_request_n_o(mreq), .sequential_address_o(seq),
      .data_o(pd), .data_oe_o(poe), .cmd_go_i(go), .cmd_write_i(cwr), .cmd_addr_i(ca),
      .cmd_data_i(cd), .cmd_lanes_i(cl), .done_o(done), .rd_data_o(pdat),
      .abort_seen_o(aseen), .viol_o(viol));
   // ****************************************
   // Bus tasks and report
   // ****************************************
   task automatic complete_run();
      if (err_total == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         err_total++;
      end
   endtask : check
   task automatic reg_wr(input logic [7:0] adr, input logic [31:0] d);
      @(posedge clk_i);
      ra <= adr;
      wd <= d;
      ws <= 1'b1;
      @(posedge clk_i);
      ws <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] adr, output logic [31:0] val);
      @(posedge clk_i);
      ra <= adr;
      rs <= 1'b1;
      @(posedge clk_i);
      rs <= 1'b0;
      #1 val = rdat;
   endtask : reg_rd
   task automatic access(input logic w, input logic [31:0] adr, input logic [31:0] d,
      input logic [3:0] l);
      int n;
      n = 0;
      @(posedge clk_i);
      go <= 1'b1;
      cwr <= w;
      ca <= adr;
      cd <= d;
      cl <= l;
      while (done !== 1'b1 && n < 600)
      begin
         @(posedge clk_i);
         n++;
      end
      check("access end", 32'h1, done);
      go <= 1'b0;
   endtask : access
   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      last <= dw;
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         err_total++;
         complete_run();
      end
   end
   initial
   begin
      int i, idx;
      logic [31:0] adr, d;
      logic [3:0] l;
      logic w, bad;
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      check("enables", 32'h7, {abe, dbe, req_seq_output_enable});
      check("held in reset", 32'h1, {srn, wn});
      reg_rd(`MBC_OFF_CTRL, v);
      check("ctrl reset", 32'h0000_0020, v);
      reg_wr(8'h18, 32'hffff_ffff);
      reg_rd(8'h18, v);
      check("unmapped", 32'h0000_0000, v);
      reg_wr(`MBC_OFF_CTRL, 32'h0000_0021);
      for (i = 0; i < 2000 && srn !== 1'b1; i++)
         @(posedge clk_i);
      check("reset released", 32'h1, srn);
      reg_rd(`MBC_OFF_STAT, v);
      check("status", 32'h4, {v[6:4], v[2:0]});
      for (i = 0; i < 64; i++)
      begin
         mem[i] = $random(seed);
         reg_wr(`MBC_OFF_MADDR, i);
         reg_wr(`MBC_OFF_MDATA, mem[i]);
      end
      for (i = 0; i < 32; i++)
      begin
         reg_wr(`MBC_OFF_WAIT, i % 4);
         adr = $random(seed) & 32'h0000_00fc;
         bad = (i % 8 == 7);
         adr[20] = bad;
         d = $random(seed);
         l = (i % 3 == 0) ? 4'h0 : 4'($random(seed));
         w = i[0];
         access(w, adr, d, l);
         idx = adr[7:2];
         check("abort", bad, aseen);
         if (!w && !bad)
            check("read data", mem[idx], pdat);
         for (int b = 0; b < 4; b++)
            if (w && !bad && !l[b])
               mem[idx][8*b +: 8] = d[8*b +: 8];
         reg_rd(`MBC_OFF_LADDR, v);
         check("latched address", adr, v);
         reg_wr(`MBC_OFF_MADDR, idx);
         reg_rd(`MBC_OFF_MDATA, v);
         check("memory word", mem[idx], v);
      end
      for (i = 0; i < 16; i++)
      begin
         reg_wr(`MBC_OFF_CTRL, 32'h0000_0021 | (i << 1));
         @(posedge clk_i);
         v = {27'h0, i[0], i[1] & ~i[0], ~i[2], ~i[3], 1'b1};
         #1 check("mode pins", v, {bms, sas, fiq, irq, ale});
      end
      f0 = fcc;
      repeat (`MBC_FAST_CORE_CLOCK_HALF) @(posedge clk_i);
      #1 check("fast clock", {~f0}, fcc);
      m0 = mclk;
      repeat (`MBC_MCLK_HALF) @(posedge clk_i);
      #1 check("memory clock", {~m0}, mclk);
      @(posedge clk_i);
      lk <= 1'b1;
      reg_wr(`MBC_OFF_CTRL, 32'h0000_0061);
      repeat (10) @(posedge clk_i);
      check("lock blocks grant", 32'h1, abe);
      lk <= 1'b0;
      for (i = 0; i < 100 && abe !== 1'b0; i++)
         @(posedge clk_i);
      reg_rd(`MBC_OFF_STAT, v);
      check("granted", 32'h2, {abe, dbe, req_seq_output_enable, v[1:0]});
      reg_wr(`MBC_OFF_CTRL, 32'h0000_0020);
      repeat (2) @(posedge clk_i);
      check("reset again", 32'h0, {srn, trn, viol, tin});
      complete_run();
   end
endmodule : test_mbc_host
`default_nettype wire
